/* File: pkg/fp_cmd_pkg.sv */
package fp_cmd_pkg;

	// ---------------------------------------------------------------
	// Register port addresses
	// ---------------------------------------------------------------
	localparam logic [9:0] ADDR_DATA = 10'h1f0; // Data word port.
	localparam logic [9:0] ADDR_SUBCMD = 10'h1f1; // Subcommand write, error read.
	localparam logic [9:0] ADDR_SECT_CNT = 10'h1f2; // Sector count.
	localparam logic [9:0] ADDR_SECT_NUM = 10'h1f3; // Sector number.
	localparam logic [9:0] ADDR_CYL_LO = 10'h1f4; // Cylinder low.
	localparam logic [9:0] ADDR_CYL_HI = 10'h1f5; // Cylinder high.
	localparam logic [9:0] ADDR_DRV_HEAD = 10'h1f6; // Drive and head select.
	localparam logic [9:0] ADDR_CMD = 10'h1f7; // Command write, status read.

	// ---------------------------------------------------------------
	// Command, subcommands and key values
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_FAIL_PRED = 8'hb0; // Failure-prediction command.
	localparam logic [7:0] SUB_READ_VALUES = 8'hd0; // Read attribute values.
	localparam logic [7:0] SUB_READ_THRESH = 8'hd1; // Read thresholds.
	localparam logic [7:0] SUB_AUTOSAVE = 8'hd2; // Autosave control.
	localparam logic [7:0] SUB_SAVE = 8'hd3; // Save attribute values.
	localparam logic [7:0] SUB_ENABLE = 8'hd8; // Enable prediction.
	localparam logic [7:0] SUB_DISABLE = 8'hd9; // Disable prediction.
	localparam logic [7:0] SUB_STATUS = 8'hda; // Return pass or fail verdict.
	localparam logic [7:0] KEY_LO = 8'h4f; // Key and pass value, cylinder low.
	localparam logic [7:0] KEY_HI = 8'hc2; // Key and pass value, cylinder high.
	localparam logic [7:0] FAIL_LO = 8'hf4; // Fail value, cylinder low.
	localparam logic [7:0] FAIL_HI = 8'h2c; // Fail value, cylinder high.
	localparam logic [7:0] AUTOSAVE_OFF = 8'h00; // Sector count that disables autosave.

	// ---------------------------------------------------------------
	// Status and error bit positions, reset values
	// ---------------------------------------------------------------
	localparam int STS_BUSY = 7; // Busy bit.
	localparam int STS_READY = 6; // Device ready bit.
	localparam int STS_DRQ = 3; // Data request bit.
	localparam int STS_ERR = 0; // Error bit.
	localparam int ERR_ABORT = 2; // Aborted command bit.
	localparam int DRV_SEL_BIT = 4; // Drive select bit of drive_head_reg.
	localparam logic [7:0] REG_RESET = 8'h00; // Reset value of taskfile registers.

	// ---------------------------------------------------------------
	// Data tables and attribute layout (16-bit words)
	// ---------------------------------------------------------------
	localparam int XFER_WORDS = 256; // 512 bytes per table.
	localparam int ATTR_COUNT = 30; // Attribute slots per table.
	localparam int ATTR_STRIDE = 6; // Words per attribute slot.
	localparam int ATTR_BASE_THR = 1; // Word with ID (low) and threshold (high).
	localparam int ATTR_BASE_VAL = 2; // Word with current value (high byte).
	localparam logic TBL_VALUES = 1'b0; // Attribute value table select.
	localparam logic TBL_THRESH = 1'b1; // Threshold table select.

	// ---------------------------------------------------------------
	// Autosave period
	// ---------------------------------------------------------------
	localparam longint unsigned AUTOSAVE_MIN = 64'd15; // Autosave period in minutes.
	localparam longint unsigned CLK_PERIOD_NS = 64'd8; // Clock period in ns.
	localparam longint unsigned AUTOSAVE_CYCLES = AUTOSAVE_MIN * 64'd60 *
		64'd1_000_000_000 / CLK_PERIOD_NS; // Autosave period in clock cycles.

	// Word address into the attribute source.
	typedef struct packed {
		logic tbl; // Table select.
		logic [7:0] word; // Word index within the table.
	} src_addr_t;

	// Settings kept in nonvolatile storage.
	typedef struct packed {
		logic pred_en; // Failure prediction enabled.
		logic autosave_en; // Attribute autosave enabled.
	} nv_cfg_t;

endpackage

/* File: logic/autosave_timer.sv */
`timescale 1ns/1ps
module autosave_timer #(
	parameter longint unsigned PERIOD = 64'd1000 // Cycles between saves.
) (
	input wire logic sys_clk_i, // Clock.
	input wire logic rstn_i, // Synchronous reset, active low.
	input wire logic run_i, // Counting allowed.
	input wire logic restart_i, // A save finished, start over.
	output logic expire_o // One-cycle pulse when the period has elapsed.
);

	// ---------------------------------------------------------------
	// Elapsed-time counter
	// ---------------------------------------------------------------
	logic [39:0] count_q; // Cycles since the previous save.
	localparam logic [39:0] LAST = 40'(PERIOD - 64'd1); // Final count.

	// The count holds while stopped so that time already elapsed is kept.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i || restart_i) begin
			count_q <= 40'h0;
		end else if (run_i && count_q != LAST) begin
			count_q <= count_q + 40'h1;
		end
	end

	// Expiry fires once; the owner restarts the count after saving.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			expire_o <= 1'b0;
		end else begin
			expire_o <= run_i && !restart_i && count_q == LAST - 40'h1;
		end
	end

endmodule

/* File: logic/threshold_compare.sv */
`timescale 1ns/1ps
module threshold_compare (
	input wire logic sys_clk_i, // Clock.
	input wire logic rstn_i, // Synchronous reset, active low.
	input wire logic start_i, // Start a walk over all attributes.
	output fp_cmd_pkg::src_addr_t addr_o, // Source word address.
	input wire logic [15:0] data_i, // Source word at addr_o.
	output logic done_o, // One-cycle pulse at the end of the walk.
	output logic fail_o // Some attribute is below its threshold.
);

	// ---------------------------------------------------------------
	// Walk state
	// ---------------------------------------------------------------
	logic busy_q; // Walk in progress.
	logic phase_q; // Low: threshold word, high: value word.
	logic [4:0] idx_q; // Attribute slot.
	logic [7:0] id_q; // Latched attribute ID.
	logic [7:0] thr_q; // Latched threshold.
	logic [7:0] base; // First word of the slot.

	assign base = 8'(idx_q * fp_cmd_pkg::ATTR_STRIDE);

	// The address is formed from registers only, so the source sees it steady.
	always_comb begin
		addr_o.tbl = phase_q ? fp_cmd_pkg::TBL_VALUES : fp_cmd_pkg::TBL_THRESH;
		addr_o.word = base + (phase_q ? 8'(fp_cmd_pkg::ATTR_BASE_VAL) :
			8'(fp_cmd_pkg::ATTR_BASE_THR));
	end

	// One slot takes two cycles; unused slots (ID zero) never fail.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			busy_q <= 1'b0;
			phase_q <= 1'b0;
			idx_q <= 5'h0;
			id_q <= 8'h00;
			thr_q <= 8'h00;
			fail_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				busy_q <= 1'b1;
				phase_q <= 1'b0;
				idx_q <= 5'h0;
				fail_o <= 1'b0;
			end else if (busy_q && !phase_q) begin
				id_q <= data_i[7:0];
				thr_q <= data_i[15:8];
				phase_q <= 1'b1;
			end else if (busy_q) begin
				if (id_q != 8'h00 && data_i[15:8] < thr_q) begin
					fail_o <= 1'b1;
				end
				phase_q <= 1'b0;
				if (idx_q == 5'(fp_cmd_pkg::ATTR_COUNT - 1)) begin
					busy_q <= 1'b0;
					done_o <= 1'b1;
				end else begin
					idx_q <= idx_q + 5'h1;
				end
			end
		end
	end

endmodule

/* File: logic/ata_failure_prediction_cmd.sv */
`timescale 1ns/1ps
module ata_failure_prediction_cmd #(
	parameter longint unsigned AUTOSAVE_CYCLES = fp_cmd_pkg::AUTOSAVE_CYCLES, // Autosave period.
	parameter logic DEV_SELECT = 1'b0 // Drive select value this device answers to.
) (
	input wire logic sys_clk_i, // Clock, 125 MHz.
	input wire logic rstn_i, // Synchronous reset, active low.
	input wire logic [9:0] addr_i, // Register port address.
	input wire logic wr_i, // Write strobe, one cycle.
	input wire logic rd_i, // Read strobe, one cycle.
	input wire logic [15:0] data_i, // Write data, low byte for registers.
	output logic [15:0] data_o, // Read data.
	output logic data_oe_n_o, // Low while the device drives the data lines.
	output fp_cmd_pkg::src_addr_t src_addr_o, // Attribute source word address.
	input wire logic [15:0] src_data_i, // Attribute source word.
	output logic media_save_o, // Level: attribute save to medium requested.
	input wire logic media_done_i, // Pulse: medium save finished.
	input wire fp_cmd_pkg::nv_cfg_t nv_cfg_i, // Settings read from storage.
	output fp_cmd_pkg::nv_cfg_t nv_cfg_o, // Settings to store.
	output logic nv_write_o // Pulse: store nv_cfg_o.
);

	// ---------------------------------------------------------------
	// Command sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, // Waiting for a command.
		ST_CHECK, // Validating keys and subcommand.
		ST_COMMIT, // Waiting for the medium save.
		ST_COMPARE, // Walking attributes against thresholds.
		ST_XFER // Sending a 512-byte table.
	} state_t;

	state_t state_q; // Sequencer state.
	logic [7:0] subcmd_q; // subcommand_reg.
	logic [7:0] error_q; // error_reg.
	logic [7:0] sect_cnt_q; // sector_count_reg.
	logic [7:0] sect_num_q; // sector_number_reg.
	logic [7:0] cyl_lo_q; // cylinder_low_reg.
	logic [7:0] cyl_hi_q; // cylinder_high_reg.
	logic [7:0] drv_head_q; // drive_head_reg.
	logic busy_q; // Busy status bit.
	logic drq_q; // Data request status bit.
	logic err_q; // Error status bit.
	logic auto_q; // Current save is an automatic one.
	logic auto_pend_q; // Autosave period elapsed, save pending.
	logic loaded_q; // Stored settings have been taken in.
	fp_cmd_pkg::nv_cfg_t cfg_q; // Live settings.
	logic xfer_tbl_q; // Table being sent.
	logic [7:0] word_q; // Next word to send.
	logic cmp_start_q; // Start pulse for the comparator.
	logic cmp_done; // Comparator finished.
	logic cmp_fail; // Comparator verdict.
	fp_cmd_pkg::src_addr_t cmp_addr; // Comparator source address.
	logic timer_expire; // Autosave period elapsed.
	logic cmd_wr; // Host issues the command this cycle.
	logic keys_ok; // Cylinder keys match.
	logic sub_known; // Subcommand code is supported.
	logic [7:0] status; // Status byte as read.

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------
	// A command is taken only when idle and addressed to this drive.
	assign cmd_wr = wr_i && addr_i == fp_cmd_pkg::ADDR_CMD && !busy_q && !drq_q &&
		drv_head_q[fp_cmd_pkg::DRV_SEL_BIT] == DEV_SELECT;
	assign keys_ok = cyl_lo_q == fp_cmd_pkg::KEY_LO && cyl_hi_q == fp_cmd_pkg::KEY_HI;

	// Supported subcommand codes.
	always_comb begin
		sub_known = subcmd_q == fp_cmd_pkg::SUB_READ_VALUES ||
			subcmd_q == fp_cmd_pkg::SUB_READ_THRESH ||
			subcmd_q == fp_cmd_pkg::SUB_AUTOSAVE ||
			subcmd_q == fp_cmd_pkg::SUB_SAVE ||
			subcmd_q == fp_cmd_pkg::SUB_ENABLE ||
			subcmd_q == fp_cmd_pkg::SUB_DISABLE ||
			subcmd_q == fp_cmd_pkg::SUB_STATUS;
	end

	// Status byte; ready is shown whenever the device is not busy.
	always_comb begin
		status = 8'h00;
		status[fp_cmd_pkg::STS_BUSY] = busy_q;
		status[fp_cmd_pkg::STS_READY] = !busy_q;
		status[fp_cmd_pkg::STS_DRQ] = drq_q;
		status[fp_cmd_pkg::STS_ERR] = err_q;
	end

	// ---------------------------------------------------------------
	// Attribute source address
	// ---------------------------------------------------------------
	// The comparator owns the source only while it walks.
	always_comb begin
		if (state_q == ST_COMPARE) begin
			src_addr_o = cmp_addr;
		end else begin
			src_addr_o.tbl = xfer_tbl_q;
			src_addr_o.word = word_q;
		end
	end

	// ---------------------------------------------------------------
	// Taskfile registers
	// ---------------------------------------------------------------
	// Host writes are ignored while busy so a running command sees steady inputs.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			subcmd_q <= fp_cmd_pkg::REG_RESET;
			sect_cnt_q <= fp_cmd_pkg::REG_RESET;
			sect_num_q <= fp_cmd_pkg::REG_RESET;
			drv_head_q <= fp_cmd_pkg::REG_RESET;
		end else if (wr_i && !busy_q) begin
			if (addr_i == fp_cmd_pkg::ADDR_SUBCMD) begin
				subcmd_q <= data_i[7:0];
			end else if (addr_i == fp_cmd_pkg::ADDR_SECT_CNT) begin
				sect_cnt_q <= data_i[7:0];
			end else if (addr_i == fp_cmd_pkg::ADDR_SECT_NUM) begin
				sect_num_q <= data_i[7:0];
			end else if (addr_i == fp_cmd_pkg::ADDR_DRV_HEAD) begin
				drv_head_q <= data_i[7:0];
			end
		end
	end

	// Cylinder registers carry the keys in and the verdict out.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			cyl_lo_q <= fp_cmd_pkg::REG_RESET;
			cyl_hi_q <= fp_cmd_pkg::REG_RESET;
		end else if (state_q == ST_COMPARE && cmp_done) begin
			if (cmp_fail) begin
				cyl_lo_q <= fp_cmd_pkg::FAIL_LO;
				cyl_hi_q <= fp_cmd_pkg::FAIL_HI;
			end else begin
				cyl_lo_q <= fp_cmd_pkg::KEY_LO;
				cyl_hi_q <= fp_cmd_pkg::KEY_HI;
			end
		end else if (wr_i && !busy_q) begin
			if (addr_i == fp_cmd_pkg::ADDR_CYL_LO) begin
				cyl_lo_q <= data_i[7:0];
			end else if (addr_i == fp_cmd_pkg::ADDR_CYL_HI) begin
				cyl_hi_q <= data_i[7:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// Read data is registered; it drives the lines for the cycle after rd_i.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			data_o <= 16'h0000;
			data_oe_n_o <= 1'b1;
		end else begin
			data_oe_n_o <= !rd_i;
			if (!rd_i) begin
				data_o <= 16'h0000;
			end else if (addr_i == fp_cmd_pkg::ADDR_DATA) begin
				data_o <= drq_q ? src_data_i : 16'h0000;
			end else if (busy_q) begin
				// Only status is meaningful while busy.
				data_o <= {8'h00, status};
			end else if (addr_i == fp_cmd_pkg::ADDR_SUBCMD) begin
				data_o <= {8'h00, error_q};
			end else if (addr_i == fp_cmd_pkg::ADDR_SECT_CNT) begin
				data_o <= {8'h00, sect_cnt_q};
			end else if (addr_i == fp_cmd_pkg::ADDR_SECT_NUM) begin
				data_o <= {8'h00, sect_num_q};
			end else if (addr_i == fp_cmd_pkg::ADDR_CYL_LO) begin
				data_o <= {8'h00, cyl_lo_q};
			end else if (addr_i == fp_cmd_pkg::ADDR_CYL_HI) begin
				data_o <= {8'h00, cyl_hi_q};
			end else if (addr_i == fp_cmd_pkg::ADDR_DRV_HEAD) begin
				data_o <= {8'h00, drv_head_q};
			end else if (addr_i == fp_cmd_pkg::ADDR_CMD) begin
				data_o <= {8'h00, status};
			end else begin
				data_o <= 16'h0000;
			end
		end
	end

	// ---------------------------------------------------------------
	// Persistent settings
	// ---------------------------------------------------------------
	// Stored settings are taken in the first cycle after reset release.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			loaded_q <= 1'b0;
			cfg_q <= '0;
			nv_write_o <= 1'b0;
		end else begin
			nv_write_o <= 1'b0;
			loaded_q <= 1'b1;
			if (!loaded_q) begin
				cfg_q <= nv_cfg_i;
			end else if (state_q == ST_CHECK && keys_ok && sub_known) begin
				if (subcmd_q == fp_cmd_pkg::SUB_ENABLE) begin
					cfg_q.pred_en <= 1'b1;
					nv_write_o <= 1'b1;
				end else if (cfg_q.pred_en && subcmd_q == fp_cmd_pkg::SUB_DISABLE) begin
					cfg_q.pred_en <= 1'b0;
					nv_write_o <= 1'b1;
				end else if (cfg_q.pred_en && subcmd_q == fp_cmd_pkg::SUB_AUTOSAVE) begin
					cfg_q.autosave_en <= sect_cnt_q != fp_cmd_pkg::AUTOSAVE_OFF;
					nv_write_o <= 1'b1;
				end
			end
		end
	end

	assign nv_cfg_o = cfg_q;

	// ---------------------------------------------------------------
	// Autosave scheduling
	// ---------------------------------------------------------------
	// Period counts from last save.
	autosave_timer #(
		.PERIOD(AUTOSAVE_CYCLES)
	) u_timer (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.run_i(cfg_q.autosave_en && cfg_q.pred_en),
		.restart_i(state_q == ST_COMMIT && media_done_i),
		.expire_o(timer_expire)
	);

	// A pending autosave waits for the sequencer; expiry beats the clear.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			auto_pend_q <= 1'b0;
		end else if (timer_expire) begin
			auto_pend_q <= 1'b1;
		end else if (!cfg_q.pred_en || (state_q == ST_COMMIT && media_done_i)) begin
			auto_pend_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Threshold comparison
	// ---------------------------------------------------------------
	// Each attribute against its threshold.
	threshold_compare u_cmp (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.start_i(cmp_start_q),
		.addr_o(cmp_addr),
		.data_i(src_data_i),
		.done_o(cmp_done),
		.fail_o(cmp_fail)
	);

	// ---------------------------------------------------------------
	// Command sequencer
	// ---------------------------------------------------------------
	// Busy brackets every subcommand; the medium save request is a level.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
			drq_q <= 1'b0;
			err_q <= 1'b0;
			error_q <= 8'h00;
			auto_q <= 1'b0;
			media_save_o <= 1'b0;
			cmp_start_q <= 1'b0;
			xfer_tbl_q <= fp_cmd_pkg::TBL_VALUES;
			word_q <= 8'h00;
		end else begin
			cmp_start_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (cmd_wr && data_i[7:0] == fp_cmd_pkg::CMD_FAIL_PRED) begin
						busy_q <= 1'b1;
						err_q <= 1'b0;
						error_q <= 8'h00;
						state_q <= ST_CHECK;
					end else if (auto_pend_q && cfg_q.pred_en && !drq_q) begin
						busy_q <= 1'b1;
						auto_q <= 1'b1;
						media_save_o <= 1'b1;
						state_q <= ST_COMMIT;
					end
				end
				ST_CHECK: begin
					state_q <= ST_IDLE;
					if (!keys_ok || !sub_known ||
						(!cfg_q.pred_en && subcmd_q != fp_cmd_pkg::SUB_ENABLE)) begin
						busy_q <= 1'b0;
						err_q <= 1'b1;
						error_q[fp_cmd_pkg::ERR_ABORT] <= 1'b1;
					end else if (subcmd_q == fp_cmd_pkg::SUB_READ_VALUES ||
						subcmd_q == fp_cmd_pkg::SUB_SAVE ||
						subcmd_q == fp_cmd_pkg::SUB_STATUS) begin
						auto_q <= 1'b0;
						media_save_o <= 1'b1;
						state_q <= ST_COMMIT;
					end else if (subcmd_q == fp_cmd_pkg::SUB_READ_THRESH) begin
						busy_q <= 1'b0;
						drq_q <= 1'b1;
						xfer_tbl_q <= fp_cmd_pkg::TBL_THRESH;
						word_q <= 8'h00;
						state_q <= ST_XFER;
					end else begin
						busy_q <= 1'b0;
					end
				end
				ST_COMMIT: begin
					if (media_done_i) begin
						media_save_o <= 1'b0;
						if (auto_q) begin
							busy_q <= 1'b0;
							auto_q <= 1'b0;
							state_q <= ST_IDLE;
						end else if (subcmd_q == fp_cmd_pkg::SUB_READ_VALUES) begin
							busy_q <= 1'b0;
							drq_q <= 1'b1;
							xfer_tbl_q <= fp_cmd_pkg::TBL_VALUES;
							word_q <= 8'h00;
							state_q <= ST_XFER;
						end else if (subcmd_q == fp_cmd_pkg::SUB_STATUS) begin
							cmp_start_q <= 1'b1;
							state_q <= ST_COMPARE;
						end else begin
							busy_q <= 1'b0;
							state_q <= ST_IDLE;
						end
					end
				end
				ST_COMPARE: begin
					if (cmp_done) begin
						busy_q <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_XFER: begin
					// Each data-port read takes one word; the last ends the request.
					if (rd_i && addr_i == fp_cmd_pkg::ADDR_DATA) begin
						word_q <= word_q + 8'h01;
						if (word_q == 8'(fp_cmd_pkg::XFER_WORDS - 1)) begin
							drq_q <= 1'b0;
							state_q <= ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

/* File: test/fp_cmd_chk.sv */
`timescale 1ns/1ps
module fp_cmd_chk #(
	parameter longint unsigned AUTOSAVE_CYCLES = 64'd100 // Autosave period.
) (
	input wire logic sys_clk_i, // Clock.
	input wire logic rstn_i, // Reset, active low.
	input wire logic [9:0] addr_i, // Address.
	input wire logic wr_i, // Write strobe.
	input wire logic rd_i, // Read strobe.
	input wire logic [15:0] data_i, // Write data.
	input wire logic [15:0] data_o, // Read data.
	input wire logic data_oe_n_o, // Bus drive, low active.
	input wire logic media_save_o, // Save request.
	input wire logic media_done_i, // Save finished.
	input wire fp_cmd_pkg::nv_cfg_t nv_cfg_o, // Live settings.
	input wire logic nv_write_o // Store strobe.
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	property p_oe; rd_i |=> !data_oe_n_o; endproperty
	a_oe: assert property (p_oe) else $error("bus idle after read");
	property p_zero; !rd_i |=> data_o == 16'h0000 && data_oe_n_o; endproperty
	a_zero: assert property (p_zero) else $error("data without read");
	property p_busy;
		wr_i && addr_i == 10'h1f7 && data_i[7:0] == 8'hb0 ##1 rd_i && addr_i == 10'h1f7
		|=> data_o[7];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not set");
	property p_hold; media_save_o && !media_done_i |=> media_save_o; endproperty
	a_hold: assert property (p_hold) else $error("save dropped early");
	property p_drop; media_save_o && media_done_i |=> !media_save_o; endproperty
	a_drop: assert property (p_drop) else $error("save held after done");
	property p_nvchg; $changed(nv_cfg_o) && $past(rstn_i, 2) |-> nv_write_o; endproperty
	a_nvchg: assert property (p_nvchg) else $error("setting not stored");
	property p_nvpulse; nv_write_o |=> !nv_write_o; endproperty
	a_nvpulse: assert property (p_nvpulse) else $error("store strobe long");
	property p_nvcause; nv_write_o |-> $past(wr_i, 2) && $past(addr_i, 2) == 10'h1f7; endproperty
	a_nvcause: assert property (p_nvcause) else $error("store without command");
	property p_predoff; !nv_cfg_o.pred_en && !media_save_o |=> !media_save_o; endproperty
	a_predoff: assert property (p_predoff) else $error("save while disabled");
	c_store: cover property (nv_write_o);
	c_save: cover property (media_save_o && media_done_i);
	// A table word shows on the lines in the cycle after its read strobe.
	c_table: cover property (rd_i && addr_i == 10'h1f0 ##1 data_o != 16'h0000);
endmodule
bind ata_failure_prediction_cmd fp_cmd_chk #(.AUTOSAVE_CYCLES(AUTOSAVE_CYCLES)) u_chk (.*);

/* File: test/fp_store_model.sv */
`timescale 1ns/1ps
module fp_store_model (
	input wire logic sys_clk_i, // Clock.
	input wire fp_cmd_pkg::src_addr_t src_addr_i, // Word address.
	output logic [15:0] src_data_o, // Word at that address.
	input wire logic save_i, // Save request.
	output logic done_o = 1'b0, // Save finished pulse.
	input wire logic slow_i, // Long save time.
	input wire logic fail_i, // Slot 0 under its threshold.
	input wire logic nv_write_i, // Store strobe.
	input wire fp_cmd_pkg::nv_cfg_t nv_i, // Settings to store.
	output fp_cmd_pkg::nv_cfg_t nv_o = '0 // Stored settings, no reset.
);
	int wait_n = 0;
	// Only slot 0 is live; other words never fall under a threshold.
	always_comb begin
		src_data_o = {src_addr_i.tbl ? 8'h00 : 8'h02, src_addr_i.word};
		if (src_addr_i.tbl && src_addr_i.word == 8'h01)
			src_data_o = 16'h5001;
		if (!src_addr_i.tbl && src_addr_i.word == 8'h02)
			src_data_o = fail_i ? 16'h4000 : 16'h6000;
	end
	// Medium answers quickly or slowly; storage survives device resets.
	always @(posedge sys_clk_i) begin
		done_o <= 1'b0;
		if (nv_write_i)
			nv_o <= nv_i;
		if (save_i && !done_o)
			wait_n <= (wait_n >= (slow_i ? 20 : 2)) ? 0 : wait_n + 1;
		if (save_i && !done_o && wait_n >= (slow_i ? 20 : 2))
			done_o <= 1'b1;
	end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, fail = 1'b0, slow = 1'b0;
	logic ms_q = 1'b0, msave, mdone, nvw, oe_n;
	logic [9:0] addr = 10'h000;
	logic [15:0] wdat = 16'h0000, rdat, sdat, st;
	fp_cmd_pkg::src_addr_t sa;
	fp_cmd_pkg::nv_cfg_t cfg_o, cfg_st;
	int n_mismatch = 0, num_checks = 0, n_save = 0, pred = 0, asv = 0;
	initial forever #4 sys_clk = ~sys_clk;
	ata_failure_prediction_cmd #(.AUTOSAVE_CYCLES(64'd100)) dut (.sys_clk_i(sys_clk),
		.rstn_i(rstn), .addr_i(addr), .wr_i(wr), .rd_i(rd), .data_i(wdat), .data_o(rdat),
		.data_oe_n_o(oe_n), .src_addr_o(sa), .src_data_i(sdat), .media_save_o(msave),
		.media_done_i(mdone), .nv_cfg_i(cfg_st), .nv_cfg_o(cfg_o), .nv_write_o(nvw));
	fp_store_model store (.sys_clk_i(sys_clk), .src_addr_i(sa), .src_data_o(sdat),
		.save_i(msave), .done_o(mdone), .slow_i(slow), .fail_i(fail), .nv_write_i(nvw),
		.nv_i(cfg_o), .nv_o(cfg_st));
	// Count the starts of medium saves.
	always @(posedge sys_clk) begin
		ms_q <= msave;
		if (msave && !ms_q)
			n_save++;
	end
	function automatic logic [15:0] ew(logic t, int k);
		if (t && k == 1)
			return 16'h5001;
		if (!t && k == 2)
			return fail ? 16'h4000 : 16'h6000;
		return {t ? 8'h00 : 8'h02, 8'(k)};
	endfunction
	task automatic chk(logic [15:0] g, logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Each access leaves one quiet cycle so a strobe is never re-driven at once.
	task automatic acc(logic w, logic [9:0] a, logic [7:0] d, output logic [15:0] v);
		addr = a;
		wdat = {8'h00, d};
		wr = w;
		rd = !w;
		@(posedge sys_clk);
		#1 wr = 1'b0;
		rd = 1'b0;
		v = rdat;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic idle();
		for (int i = 0; i < 300 && (i == 0 || st[7] !== 1'b0); i++)
			acc(1'b0, 10'h1f7, 8'h00, st);
	endtask
	task automatic smart(logic [7:0] sub, logic [7:0] sc, logic [7:0] key);
		logic [15:0] v;
		logic ab;
		ab = key != 8'h4f || !(sub inside {8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd8, 8'hd9, 8'hda})
			|| (pred == 0 && sub != 8'hd8);
		slow = 1'($urandom);
		idle();
		acc(1'b1, 10'h1f1, sub, v);
		acc(1'b1, 10'h1f2, sc, v);
		acc(1'b1, 10'h1f4, key, v);
		acc(1'b1, 10'h1f5, 8'hc2, v);
		acc(1'b1, 10'h1f6, 8'h00, v);
		addr = 10'h1f7;
		wdat = 16'h00b0;
		wr = 1'b1;
		@(posedge sys_clk);
		#1 wr = 1'b0;
		rd = 1'b1;
		@(posedge sys_clk);
		#1 rd = 1'b0;
		chk(rdat[7], 1'b1);
		@(posedge sys_clk);
		#1 idle();
		chk(st[7:0], {4'h4, sub[7:1] == 7'h68 && !ab, 2'b00, ab});
		acc(1'b0, 10'h1f1, 8'h00, v);
		chk(v[7:0], ab ? 8'h04 : 8'h00);
		if (!ab && sub == 8'hd8)
			pred = 1;
		if (!ab && sub == 8'hd9)
			pred = 0;
		if (!ab && sub == 8'hd2)
			asv = int'(sc != 8'h00);
		chk(cfg_o, {pred[0], asv[0]});
		for (int k = 0; k < 256 && !ab && sub[7:1] == 7'h68; k++) begin
			acc(1'b0, 10'h1f0, 8'h00, v);
			chk(v, ew(sub[0], k));
		end
		acc(1'b0, 10'h1f4, 8'h00, v);
		if (!ab && sub == 8'hda)
			chk(v[7:0], fail ? 8'hf4 : 8'h4f);
		acc(1'b0, 10'h1f5, 8'h00, v);
		if (!ab && sub == 8'hda)
			chk(v[7:0], fail ? 8'h2c : 8'hc2);
	endtask
	task automatic saves(int e);
		n_save = 0;
		repeat (250) @(posedge sys_clk);
		#1 chk(16'(n_save), 16'(e));
	endtask
	task automatic rst();
		rstn = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 rstn = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	initial begin
		#200000 n_mismatch++;
		stop_test();
	end
	initial begin
		void'($urandom(52494));
		rst();
		smart(8'hd8, 8'h00, 8'h00);
		smart(8'hd0, 8'h00, 8'h4f);
		smart(8'hd8, 8'h00, 8'h4f);
		smart(8'h55, 8'h00, 8'h4f);
		smart(8'hd1, 8'h00, 8'h4f);
		smart(8'hd0, 8'h00, 8'h4f);
		smart(8'hd3, 8'h00, 8'h4f);
		smart(8'hda, 8'h00, 8'h4f);
		fail = 1'b1;
		smart(8'hda, 8'h00, 8'h4f);
		smart(8'hd2, 8'($urandom_range(255, 1)), 8'h4f);
		saves(2);
		smart(8'hd2, 8'h00, 8'h4f);
		saves(0);
		smart(8'hd2, 8'h01, 8'h4f);
		smart(8'hd9, 8'h00, 8'h4f);
		saves(0);
		rst();
		chk(cfg_o, 2'b01);
		stop_test();
	end
endmodule
